// [verilog/qpd_pkg.sv]
`default_nettype none
package qpd_pkg;

    // ************************************************************
    // register map (byte offsets, one word each)
    // ************************************************************
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_FAULT = 8'h08;
    localparam logic [7:0] OFS_STAT  = 8'h0c;
    localparam logic [7:0] OFS_MASK  = 8'h10;

    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_W   = 2;
    localparam int CTRL_REV_BIT  = 2;
    localparam int CTRL_INH_BIT  = 3;

    localparam logic [1:0] MODE_RST    = 2'h0;
    localparam logic       REVERSE_RST = 1'b0;
    localparam logic       INHIBIT_RST = 1'b0;

    // ************************************************************
    // event status bits, shared by status and mask
    // ************************************************************
    localparam int EV_W       = 3;
    localparam int EV_UP_BIT  = 0;
    localparam int EV_DN_BIT  = 1;
    localparam int EV_FLT_BIT = 2;
    localparam logic [EV_W-1:0] STAT_RST = 3'h0;
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;

    // ************************************************************
    // bus encodings
    // ************************************************************
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic       HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        QPD_MODE_UPDOWN = 2'h0,
        QPD_MODE_X1     = 2'h1,
        QPD_MODE_X2     = 2'h2,
        QPD_MODE_X4     = 2'h3
    } qpd_mode_type;

    typedef struct packed {
        qpd_mode_type mode;
        logic         reverse;
        logic         inhibit;
    } qpd_ctrl_type;

    typedef struct packed {
        logic a_lvl;
        logic b_lvl;
        logic a_rise;
        logic a_fall;
        logic b_rise;
        logic b_fall;
    } qpd_edge_type;

endpackage : qpd_pkg
`default_nettype wire

// [verilog/qpd_edge_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module qpd_edge_sync (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             enc_a,
    input  wire logic             enc_b,
    output qpd_pkg::qpd_edge_type edges
);
    import qpd_pkg::*;

    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] prev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= 2'h0;
            sync <= 2'h0;
            prev <= 2'h0;
        end else begin
            meta <= {enc_a, enc_b};
            sync <= meta;
            prev <= sync;
        end
    end

    always_comb begin
        edges.a_lvl  = sync[1];
        edges.b_lvl  = sync[0];
        edges.a_rise = sync[1] & ~prev[1];
        edges.a_fall = ~sync[1] & prev[1];
        edges.b_rise = sync[0] & ~prev[0];
        edges.b_fall = ~sync[0] & prev[0];
    end

endmodule : qpd_edge_sync
`default_nettype wire

// [verilog/qpd_top.sv]
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Up/down mode, normal sense: a rising A adds one, a rising B subtracts one.
// - Up/down mode, reversed sense, inhibit clear: a rising A subtracts one, a rising B adds one.
// - Up/down mode with reverse and inhibit both set: a rising A or B subtracts one.
// - Up/down: A and B rising together, or one rising as the other falls, count nothing.
// - Quadrature modes count up when A leads B and down when B leads A, before reversal.
// - X1, normal sense, B low: rising A adds one, falling A subtracts one.
// - X1, reversed sense, B low: rising A subtracts one, falling A adds one.
// - X1 with B high: no edge of A changes the count, in either sense.
// - In quadrature modes, A and B changing together is a phase fault and bumps the tally.
// - X2, normal sense: B low rise +1 fall -1; B high rise -1 fall +1.
// - X2 gives twice the X1 count for the same motion.
// - X4 gives four times the X1 count; normal sense, rising A with B low adds one.
// - The reverse setting is one bit, zero off and one on, and resets to off.
module qpd_top #(
    parameter int CW = 32,
    parameter int TW = 16
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    output logic             irq,
    output logic [CW-1:0]    count_value,
    output logic [TW-1:0]    phase_fault_tally
);
    import qpd_pkg::*;

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if (CW < 2 || CW > 32) begin : g_cw_bad
        $error("count width must be 2..32");
    end
    if (TW < 1 || TW > 32) begin : g_tw_bad
        $error("tally width must be 1..32");
    end

    localparam logic [CW-1:0] CNT_ONE  = CW'(1);
    localparam logic [TW-1:0] TAL_ONE  = TW'(1);
    localparam logic [TW-1:0] TAL_MAX  = {TW{1'b1}};
    localparam logic [TW-1:0] TAL_ZERO = '0;

    // ************************************************************
    // step decoding
    // ************************************************************
    // returns {up, down}; at most one is set
    function automatic logic [1:0] qpd_decode(input qpd_mode_type m,
                                              input qpd_edge_type e,
                                              input logic         rev,
                                              input logic         inh);
        logic up;
        logic dn;
        logic ea;
        logic eb;
        logic fwd;
        logic cnt;
        logic b_dn;
        up   = 1'b0;
        dn   = 1'b0;
        ea   = e.a_rise | e.a_fall;
        eb   = e.b_rise | e.b_fall;
        fwd  = 1'b0;
        cnt  = 1'b0;
        b_dn = 1'b0;
        unique case (m)
            QPD_MODE_UPDOWN: begin
                if (!((e.a_rise & eb) | (e.b_rise & e.a_fall))) begin
                    if (e.a_rise) begin
                        up = ~rev;
                        dn = rev;
                    end
                    // inhibit forces B down when reversed
                    b_dn = ~rev | inh;
                    if (e.b_rise) begin
                        up = ~b_dn;
                        dn = b_dn;
                    end
                end
            end
            QPD_MODE_X1: begin
                cnt = ea & ~e.b_lvl;
            end
            QPD_MODE_X2: begin
                cnt = ea;
            end
            QPD_MODE_X4: begin
                // every edge of A and B
                cnt = ea | eb;
            end
        endcase
        if (m != QPD_MODE_UPDOWN && !(ea && eb)) begin
            // A leads B: new A differs from B
            fwd = ea ? (e.a_lvl ^ e.b_lvl) : ~(e.a_lvl ^ e.b_lvl);
            up = cnt & (fwd ^ rev);
            dn = cnt & ~(fwd ^ rev);
        end
        return {up, dn};
    endfunction : qpd_decode

    // ************************************************************
    // input edges
    // ************************************************************
    qpd_edge_type edges;
    qpd_ctrl_type ctrl;
    logic [1:0]   step;
    logic         fault;

    qpd_edge_sync u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .enc_a   (enc_a),
        .enc_b   (enc_b),
        .edges   (edges)
    );

    assign step = qpd_decode(ctrl.mode, edges, ctrl.reverse, ctrl.inhibit);
    assign fault = (ctrl.mode != QPD_MODE_UPDOWN)
                 & (edges.a_rise | edges.a_fall)
                 & (edges.b_rise | edges.b_fall);

    // ************************************************************
    // ahb-lite slave
    // ************************************************************
    logic            wr_pend;
    logic [7:0]      wr_addr;
    logic            wr_ctrl;
    logic            wr_count;
    logic            wr_fault;
    logic            wr_stat;
    logic            wr_mask;
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] mask;
    logic            take;
    logic [31:0]     next_rdata;

    assign take = hsel & hready & htrans[1];

    // zero wait states, so write data lands one cycle after its address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h0;
        end else if (hready) begin
            wr_pend <= take & hwrite & (hsize == HSIZE_WORD);
            wr_addr <= haddr[7:0];
        end
    end

    assign wr_ctrl  = wr_pend & (wr_addr == OFS_CTRL);
    assign wr_count = wr_pend & (wr_addr == OFS_COUNT);
    assign wr_fault = wr_pend & (wr_addr == OFS_FAULT);
    assign wr_stat  = wr_pend & (wr_addr == OFS_STAT);
    assign wr_mask  = wr_pend & (wr_addr == OFS_MASK);

    always_comb begin
        next_rdata = 32'h0;
        unique case (haddr[7:0])
            OFS_CTRL: begin
                next_rdata[CTRL_MODE_LSB +: CTRL_MODE_W] = ctrl.mode;
                next_rdata[CTRL_REV_BIT]                 = ctrl.reverse;
                next_rdata[CTRL_INH_BIT]                 = ctrl.inhibit;
            end
            OFS_COUNT: next_rdata[CW-1:0] = count_value;
            OFS_FAULT: next_rdata[TW-1:0] = phase_fault_tally;
            OFS_STAT:  next_rdata[EV_W-1:0] = stat;
            OFS_MASK:  next_rdata[EV_W-1:0] = mask;
            default:   next_rdata = 32'h0;
        endcase
    end

    // read data registered in the address phase; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
            if (take && !hwrite) begin
                hrdata <= next_rdata;
            end
        end
    end

    // ************************************************************
    // configuration
    // ************************************************************
    // one reverse bit, off after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl.mode    <= qpd_mode_type'(MODE_RST);
            ctrl.reverse <= REVERSE_RST;
            ctrl.inhibit <= INHIBIT_RST;
        end else if (wr_ctrl) begin
            ctrl.mode    <= qpd_mode_type'(hwdata[CTRL_MODE_LSB +: CTRL_MODE_W]);
            ctrl.reverse <= hwdata[CTRL_REV_BIT];
            ctrl.inhibit <= hwdata[CTRL_INH_BIT];
        end
    end

    // ************************************************************
    // count and fault tally
    // ************************************************************
    // a software preset takes precedence over a step in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_value <= '0;
        end else if (wr_count) begin
            count_value <= hwdata[CW-1:0];
        end else if (step[1]) begin
            count_value <= count_value + CNT_ONE;
        end else if (step[0]) begin
            count_value <= count_value - CNT_ONE;
        end
    end

    // saturates rather than wraps, so a flood of faults is never hidden;
    // a fault in the clearing cycle survives as a count of one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_fault_tally <= TAL_ZERO;
        end else if (wr_fault) begin
            phase_fault_tally <= fault ? TAL_ONE : TAL_ZERO;
        end else if (fault && phase_fault_tally != TAL_MAX) begin
            phase_fault_tally <= phase_fault_tally + TAL_ONE;
        end
    end

    // ************************************************************
    // interrupts
    // ************************************************************
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] next_stat;
    logic [EV_W-1:0] next_mask;

    always_comb begin
        ev             = '0;
        ev[EV_UP_BIT]  = step[1];
        ev[EV_DN_BIT]  = step[0];
        ev[EV_FLT_BIT] = fault;
        next_stat      = stat;
        if (wr_stat) begin
            next_stat = stat & ~hwdata[EV_W-1:0];
        end
        // new events win over a write-one clear
        next_stat = next_stat | ev;
        next_mask = wr_mask ? hwdata[EV_W-1:0] : mask;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat <= STAT_RST;
            mask <= MASK_RST;
            irq  <= 1'b0;
        end else begin
            stat <= next_stat;
            mask <= next_mask;
            irq  <= |(next_stat & next_mask);
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic a_only_rise;
    logic b_only_rise;
    assign a_only_rise = edges.a_rise & ~edges.b_rise & ~edges.b_fall;
    assign b_only_rise = edges.b_rise & ~edges.a_rise & ~edges.a_fall;

    ud_up_a_a: assert property (
        (ctrl.mode == QPD_MODE_UPDOWN) && !ctrl.reverse && a_only_rise && !wr_count
        |=> count_value == $past(count_value) + CNT_ONE)
        else $error("up/down: rising A did not add one");

    ud_rev_b_a: assert property (
        (ctrl.mode == QPD_MODE_UPDOWN) && ctrl.reverse && !ctrl.inhibit
        && b_only_rise && !wr_count
        |=> count_value == $past(count_value) + CNT_ONE)
        else $error("up/down reversed: rising B did not add one");

    ud_inhibit_a: assert property (
        (ctrl.mode == QPD_MODE_UPDOWN) && ctrl.reverse && ctrl.inhibit
        && (a_only_rise || b_only_rise) && !wr_count
        |=> count_value == $past(count_value) - CNT_ONE)
        else $error("up/down inhibit: rise did not subtract one");

    ud_collide_a: assert property (
        (ctrl.mode == QPD_MODE_UPDOWN) && edges.a_rise
        && (edges.b_rise || edges.b_fall) && !wr_count
        |=> $stable(count_value) && !stat[EV_UP_BIT] || $past(stat[EV_UP_BIT]))
        else $error("up/down: colliding edges changed the count");

    x1_fall_a: assert property (
        (ctrl.mode == QPD_MODE_X1) && !ctrl.reverse && edges.a_fall
        && !edges.b_lvl && !edges.b_rise && !edges.b_fall && !wr_count
        |=> count_value == $past(count_value) - CNT_ONE)
        else $error("x1: falling A with B low did not subtract one");

    x1_b_high_a: assert property (
        (ctrl.mode == QPD_MODE_X1) && edges.b_lvl && !wr_count
        |=> $stable(count_value))
        else $error("x1: count moved while B high");

    phase_fault_a: assert property (
        (ctrl.mode != QPD_MODE_UPDOWN) && (edges.a_rise || edges.a_fall)
        && (edges.b_rise || edges.b_fall) && !wr_fault
        && phase_fault_tally != TAL_MAX
        |=> phase_fault_tally == $past(phase_fault_tally) + TAL_ONE
            && stat[EV_FLT_BIT] && $stable(count_value) || $past(wr_count))
        else $error("quadrature: phase fault not tallied");

    x2_b_high_a: assert property (
        (ctrl.mode == QPD_MODE_X2) && !ctrl.reverse && edges.a_rise
        && edges.b_lvl && !edges.b_rise && !wr_count
        |=> count_value == $past(count_value) - CNT_ONE)
        else $error("x2: rising A with B high did not subtract one");

    x4_b_edge_a: assert property (
        (ctrl.mode == QPD_MODE_X4) && !ctrl.reverse && b_only_rise
        && edges.a_lvl && !wr_count
        |=> count_value == $past(count_value) + CNT_ONE)
        else $error("x4: rising B with A high did not add one");

    irq_level_a: assert property (
        |(stat & mask) |-> irq)
        else $error("interrupt low with unmasked status set");

endmodule : qpd_top
`default_nettype wire

// [verif/qpd_enc_model.sv]
`timescale 1ns/10ps
`default_nettype none
module qpd_enc_model (
    input  wire logic hclk,
    output var logic  enc_a,
    output var logic  enc_b
);

    // ****************************************
    // encoder lines
    // ****************************************
    initial begin
        enc_a = 1'b0;
        enc_b = 1'b0;
    end

    // phase steps
    // a push-pull source, so the lines are always driven; each level holds
    // for gap+1 cycles so the two lines are seen apart, and a step that
    // moves both lines at once is a commanded phase fault in the quadrature modes
    task automatic play(input logic [7:0] seq, input int gap);
        for (int i = 3; i >= 0; i--) begin
            @(posedge hclk);
            enc_a <= seq[2*i+1];
            enc_b <= seq[2*i];
            repeat (gap) @(posedge hclk);
        end
        repeat (6) @(posedge hclk);
    endtask : play

endmodule : qpd_enc_model
`default_nettype wire

// [verif/quadrature_pulse_count_decoder_test.sv]
`timescale 1ns/10ps
`default_nettype none
module quadrature_pulse_count_decoder_test;
    import qpd_pkg::*;

    localparam int          CEIL = 20000;
    localparam logic [31:0] BASE = 32'h0000_0100;
    // {mode, reverse, inhibit}, four {a,b} steps, signed delta, tally
    localparam logic [23:0] CASES [25] = '{
        24'h0_80_01_0, 24'h0_40_ff_0, 24'h2_80_ff_0, 24'h2_40_01_0,
        24'h3_80_ff_0, 24'h3_40_ff_0, 24'h1_80_01_0, 24'h0_c0_00_0,
        24'h0_90_01_0, 24'h0_60_ff_0, 24'h4_b4_01_0, 24'h4_78_ff_0,
        24'h6_b4_ff_0, 24'h6_78_01_0, 24'h4_c0_00_2, 24'h8_b4_02_0,
        24'h8_78_fe_0, 24'ha_b4_fe_0, 24'ha_78_02_0, 24'hc_b4_04_0,
        24'hc_78_fc_0, 24'he_b4_fc_0, 24'he_78_04_0, 24'hc_c0_00_2,
        24'hd_b4_04_0};
    localparam logic [7:0]  OFS [6] = '{OFS_CTRL, OFS_COUNT, OFS_FAULT,
                                        OFS_STAT, OFS_MASK, 8'h20};

    logic             hclk;
    logic             hresetn;
    logic             hsel;
    logic             hwrite;
    logic [31:0]      haddr;
    logic [31:0]      hwdata;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    logic [31:0]      rd;
    wire logic        hreadyout;
    wire logic        hresp;
    wire logic        irq;
    wire logic        enc_a;
    wire logic        enc_b;
    wire logic [31:0] hrdata;
    wire logic [31:0] count_value;
    wire logic [15:0] tally;
    int               err_total;
    int               num_checks;
    int               cycles;

    qpd_top dut (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .hsel              (hsel),
        .haddr             (haddr),
        .htrans            (htrans),
        .hwrite            (hwrite),
        .hsize             (hsize),
        .hwdata            (hwdata),
        .hready            (hreadyout),
        .hreadyout         (hreadyout),
        .hresp             (hresp),
        .hrdata            (hrdata),
        .enc_a             (enc_a),
        .enc_b             (enc_b),
        .irq               (irq),
        .count_value       (count_value),
        .phase_fault_tally (tally)
    );

    qpd_enc_model enc (
        .hclk  (hclk),
        .enc_a (enc_a),
        .enc_b (enc_b)
    );

    // ****************************************
    // clock, timeout, report
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    initial begin
        cycles = 0;
        forever begin
            @(posedge hclk);
            cycles++;
            if (cycles >= CEIL) begin
                err_total++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, cycles, CEIL);
                conclude();
            end
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // ****************************************
    // bus master
    // ****************************************
    // one idle edge before each address phase keeps a read clear of the
    // previous write's data phase
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, ofs};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask : bus

    task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
        bus(1'b1, ofs, wd);
    endtask : wr

    task automatic rdc(input logic [7:0] ofs, input logic [31:0] exp);
        bus(1'b0, ofs, 32'h0);
        chk(rd, exp);
    endtask : rdc

    task automatic run_case(input logic [23:0] c, input int gap);
        logic [31:0] exp;
        exp = BASE + {{24{c[11]}}, c[11:4]};
        wr(OFS_CTRL, {28'h0, c[20], c[21], c[23:22]});
        wr(OFS_COUNT, BASE);
        wr(OFS_FAULT, 32'h0);
        enc.play(c[19:12], gap);
        rdc(OFS_COUNT, exp);
        chk(count_value, exp);
        rdc(OFS_FAULT, {28'h0, c[3:0]});
        chk({16'h0, tally}, {28'h0, c[3:0]});
    endtask : run_case

    // ****************************************
    // tests
    // ****************************************
    initial begin
        err_total = 0;
        num_checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (OFS[i]) rdc(OFS[i], 32'h0);
        wr(8'h20, 32'hffff_ffff);
        rdc(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h0000_000b);
        rdc(OFS_CTRL, 32'h0000_000b);
        // a byte-sized write must be ignored
        hsize <= 3'h0;
        wr(OFS_CTRL, 32'h0000_0004);
        hsize <= HSIZE_WORD;
        rdc(OFS_CTRL, 32'h0000_000b);
        $display("test registers done");
        foreach (CASES[i]) run_case(CASES[i], 1 + 4 * (i % 3));
        $display("test counting done");
        wr(OFS_MASK, 32'h0);
        wr(OFS_STAT, 32'h7);
        run_case(24'hc_c0_00_2, 2);
        rdc(OFS_STAT, 32'h1 << EV_FLT_BIT);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_MASK, 32'h1 << EV_FLT_BIT);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_STAT, 32'h1 << EV_FLT_BIT);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        rdc(OFS_STAT, 32'h0);
        run_case(24'hc_78_fc_0, 1);
        rdc(OFS_STAT, 32'h1 << EV_DN_BIT);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_MASK, 32'h7);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_STAT, 32'h7);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        run_case(24'hc_b4_04_0, 1);
        rdc(OFS_STAT, 32'h1 << EV_UP_BIT);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_STAT, 32'h1 << EV_UP_BIT);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        $display("test interrupt done");
        conclude();
    end

endmodule : quadrature_pulse_count_decoder_test
`default_nettype wire
